// *** buck_seq_params.svh ***
// named constants for the buck protection sequencer
// assumes a single 25 MHz clock and comparator/strap levels arriving as pins
`ifndef BUCK_SEQ_PARAMS_SVH
`define BUCK_SEQ_PARAMS_SVH
`define CLK_PERIOD_NS 40
`define DEAD_TIME_NS 40
`define DEAD_CYC ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PG_RISE_NS 1000000
`define PG_FALL_NS 1500
`define UV_DELAY_NS 1000000
`define PG_RISE_CYC ((`PG_RISE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PG_FALL_CYC ((`PG_FALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UV_DELAY_CYC ((`UV_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_MAX_CYCLES 2'h3
`define DEAD_W 4
`define CNT_W 16
`define SYNC_W 28
`define STRAP_SETTLE 2'h3
`define STRAP_GND 2'h0
`define STRAP_REF2V 2'h1
`define STRAP_3V3 2'h2
`define STRAP_5V 2'h3
`endif

// *** buck_seq_pkg.sv ***
// types shared by the sequencer modules
// no assumptions beyond the params header
package buck_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEAD_HL = 3'b001,
    ST_HIGH = 3'b010,
    ST_DEAD_LH = 3'b011,
    ST_LOW = 3'b100
  } pwm_state_t;
endpackage

// *** pwm_phase.sv ***
// one channel's gate sequencing: cycle start, extension, dead time, overcurrent
// assumes all inputs already synchronous to i_clk
`timescale 1ns/1ps
`include "buck_seq_params.svh"
module pwm_phase import buck_seq_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cycle_start,
  input wire logic i_run,
  input wire logic i_peak_reached,
  input wire logic i_ocl_trip,
  input wire logic i_force_low,
  input wire logic i_force_off,
  output logic o_high_side_gate,
  output logic o_low_side_gate
);
  pwm_state_t state_q, state_d;
  logic [`DEAD_W-1:0] dead_q;
  logic [1:0] ext_q;

  // ==========================================
  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (i_cycle_start && i_run) state_d = ST_DEAD_HL;
      ST_DEAD_HL: if (dead_q == '0) state_d = ST_HIGH;
      ST_HIGH: begin
        if (i_peak_reached || i_ocl_trip) begin
          state_d = ST_DEAD_LH;
        end else if (i_cycle_start && ext_q == `EXT_MAX_CYCLES) begin
          state_d = ST_DEAD_LH;
        end
      end
      ST_DEAD_LH: if (dead_q == '0) state_d = ST_LOW;
      ST_LOW: if (i_cycle_start) state_d = ST_DEAD_HL;
      default: state_d = ST_IDLE;
    endcase
    if (i_force_low) begin
      // latched low side must ignore cycle starts
      if (state_q == ST_LOW) state_d = ST_LOW;
      else if (state_q != ST_DEAD_LH) state_d = ST_DEAD_LH;
    end else if (i_force_off || !i_run) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // ==========================================
  // dead time and extension counters
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) dead_q <= '0;
    else if (state_d != state_q) dead_q <= `DEAD_W'(`DEAD_CYC - 1);
    else if (dead_q != '0) dead_q <= dead_q - `DEAD_W'(1);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) ext_q <= '0;
    else if (state_d != ST_HIGH) ext_q <= '0;
    else if (i_cycle_start && state_q == ST_HIGH) ext_q <= ext_q + 2'h1;
  end

  // ==========================================
  // gate outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_high_side_gate <= 1'b0;
      o_low_side_gate <= 1'b0;
    end else begin
      o_high_side_gate <= (state_d == ST_HIGH);
      o_low_side_gate <= (state_d == ST_LOW);
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_no_shoot_through: assert property (!(o_high_side_gate && o_low_side_gate))
    else $error("both gates on");
  a_dead_gap_hl: assert property ($fell(o_high_side_gate) |-> !o_low_side_gate)
    else $error("low side on without dead time");
  a_ext_cut: assert property (i_cycle_start && state_q == ST_HIGH && ext_q == `EXT_MAX_CYCLES && !i_force_low
    |=> !o_high_side_gate)
    else $error("high side extended past limit");
  a_ocl_cut: assert property (i_ocl_trip && state_q == ST_HIGH |=> !o_high_side_gate ##1 o_low_side_gate || i_force_off
    || !i_run)
    else $error("overcurrent did not hand over to low side");
  sequence s_start_from_low;
    state_q == ST_LOW && i_cycle_start && i_run && !i_force_low && !i_force_off;
  endsequence
  sequence s_clear_run;
    i_run && !i_force_low && !i_force_off && !i_peak_reached && !i_ocl_trip;
  endsequence

  a_start_high: assert property (s_start_from_low ##1 s_clear_run [*2] |-> o_high_side_gate)
    else $error("high side not on after cycle start");
  a_low_hold: assert property (i_force_low && o_low_side_gate |=> o_low_side_gate)
    else $error("low side dropped while forced");
endmodule // pwm_phase

// *** buck_protection_sequencer.sv ***
// dual channel supervision: straps, lockout, protection latches, powergood, discharge
// assumes comparator, strap and enable levels are asynchronous pins
`timescale 1ns/1ps
`include "buck_seq_params.svh"
module buck_protection_sequencer import buck_seq_pkg::*; #(
  parameter int PG_RISE_CYCLES = `PG_RISE_CYC,
  parameter int UV_DELAY_CYCLES = `UV_DELAY_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_global_enable,
  input wire logic [1:0] i_channel_enable,
  input wire logic i_frequency_set_pin,
  input wire logic [1:0] i_trip_strap,
  input wire logic [1:0] i_function_strap,
  input wire logic [1:0] i_peak_reached,
  input wire logic [1:0] i_ocl_trip,
  input wire logic [1:0] i_within_5pct,
  input wire logic [1:0] i_outside_10pct,
  input wire logic [1:0] i_over_15pct,
  input wire logic [1:0] i_under_70pct,
  input wire logic [1:0] i_softstart_done,
  input wire logic [1:0] i_target_above_residual,
  input wire logic i_lockout_5v,
  input wire logic i_lockout_3v3,
  input wire logic i_lockout_ref,
  input wire logic i_over_temp,
  output logic [1:0] o_high_side_gate,
  output logic [1:0] o_low_side_gate,
  output logic [1:0] o_powergood,
  output logic [1:0] o_discharge,
  output logic [1:0] o_softstart_run,
  output logic o_rail_5v_regulator_en,
  output logic o_reference_2v_en,
  output logic o_rail_3v3_limit_low,
  output logic o_ocl_level_low,
  output logic o_current_mode
);
  // ==========================================
  // input synchronisers
  logic [`SYNC_W-1:0] sync1_q, sync2_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_global_enable, i_channel_enable, i_frequency_set_pin, i_trip_strap, i_function_strap,
                  i_peak_reached, i_ocl_trip, i_within_5pct, i_outside_10pct, i_over_15pct, i_under_70pct,
                  i_softstart_done, i_target_above_residual, i_lockout_5v, i_lockout_3v3, i_lockout_ref,
                  i_over_temp};
      sync2_q <= sync1_q;
    end
  end

  logic glob_s, sclk_s, lk5_s, lk3_s, lkr_s, ot_s;
  logic [1:0] en_s, trip_s, function_strap_s, peak_s, ocl_s, in5_s, out10_s, ov_s, uv_s, ssd_s, tgt_s;
  assign {glob_s, en_s, sclk_s, trip_s, function_strap_s, peak_s, ocl_s, in5_s, out10_s, ov_s, uv_s, ssd_s, tgt_s,
          lk5_s, lk3_s, lkr_s, ot_s} = sync2_q;

  // ==========================================
  // strap capture after reset release
  logic [1:0] settle_q;
  logic strap_ok_q, dis_en_q, ovp_en_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) settle_q <= '0;
    else if (settle_q != `STRAP_SETTLE) settle_q <= settle_q + 2'h1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_ok_q <= 1'b0;
      dis_en_q <= 1'b0;
      ovp_en_q <= 1'b0;
      o_ocl_level_low <= 1'b0;
      o_current_mode <= 1'b0;
    end else if (settle_q == `STRAP_SETTLE && !strap_ok_q) begin
      strap_ok_q <= 1'b1;
      dis_en_q <= (trip_s == `STRAP_GND) || (trip_s == `STRAP_5V);
      o_ocl_level_low <= (trip_s == `STRAP_3V3) || (trip_s == `STRAP_5V);
      ovp_en_q <= (function_strap_s == `STRAP_GND) || (function_strap_s == `STRAP_3V3);
      o_current_mode <= (function_strap_s == `STRAP_GND) || (function_strap_s == `STRAP_5V);
    end
  end

  // ==========================================
  // lockout, thermal and rails
  logic lock_any;
  assign lock_any = lk5_s || lk3_s || lkr_s;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rail_5v_regulator_en <= 1'b0;
      o_reference_2v_en <= 1'b0;
      o_rail_3v3_limit_low <= 1'b0;
    end else begin
      o_rail_5v_regulator_en <= !(lk3_s || lkr_s || ot_s);
      o_reference_2v_en <= !lk3_s;
      o_rail_3v3_limit_low <= ot_s;
    end
  end

  // ==========================================
  // switching clock edges
  logic sclk_prev_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) sclk_prev_q <= 1'b0;
    else sclk_prev_q <= sclk_s;
  end
  logic [1:0] cyc_start;
  assign cyc_start[0] = sclk_s && !sclk_prev_q;
  assign cyc_start[1] = !sclk_s && sclk_prev_q;

  // ==========================================
  // protection latches and clear
  logic [1:0] ov_latch_q, uv_latch_q, active, qualify;
  logic latch_clear, any_latched;
  assign latch_clear = !glob_s || (en_s == 2'h0) || lock_any;
  assign any_latched = |{ov_latch_q, uv_latch_q};

  genvar g;
  for (g = 0; g < 2; g++) begin : g_ch
    localparam int O = 1 - g;
    logic [`CNT_W-1:0] uv_cnt_q, pg_cnt_q;
    logic uv_hit;
    assign active[g] = glob_s && en_s[g] && !lock_any && !ot_s && strap_ok_q;
    assign qualify[g] = active[g] && ssd_s[g] && !any_latched;
    assign uv_hit = uv_s[g] && active[g] && ssd_s[g] && !ov_latch_q[g];

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) uv_cnt_q <= '0;
      else if (!uv_hit || uv_latch_q[g]) uv_cnt_q <= '0;
      else if (uv_cnt_q != `CNT_W'(UV_DELAY_CYCLES - 1)) uv_cnt_q <= uv_cnt_q + `CNT_W'(1);
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        ov_latch_q[g] <= 1'b0;
        uv_latch_q[g] <= 1'b0;
      end else begin
        ov_latch_q[g] <= (ov_s[g] && ovp_en_q && active[g]) || (ov_latch_q[g] && !latch_clear);
        uv_latch_q[g] <= (uv_hit && uv_cnt_q == `CNT_W'(UV_DELAY_CYCLES - 1))
                         || (uv_latch_q[g] && !latch_clear);
      end
    end

    pwm_phase u_phase (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_cycle_start(cyc_start[g]),
      .i_run(active[g] && tgt_s[g]),
      .i_peak_reached(peak_s[g]),
      .i_ocl_trip(ocl_s[g]),
      .i_force_low(ov_latch_q[g]),
      .i_force_off(uv_latch_q[g] || ov_latch_q[O] || uv_latch_q[O]),
      .o_high_side_gate(o_high_side_gate[g]),
      .o_low_side_gate(o_low_side_gate[g])
    );

    // powergood qualification and filter
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        pg_cnt_q <= '0;
        o_powergood[g] <= 1'b0;
      end else if (!qualify[g]) begin
        pg_cnt_q <= '0;
        o_powergood[g] <= 1'b0;
      end else if (!o_powergood[g]) begin
        if (!in5_s[g]) pg_cnt_q <= '0;
        else if (pg_cnt_q == `CNT_W'(PG_RISE_CYCLES - 1)) begin
          pg_cnt_q <= '0;
          o_powergood[g] <= 1'b1;
        end else pg_cnt_q <= pg_cnt_q + `CNT_W'(1);
      end else begin
        if (!out10_s[g]) pg_cnt_q <= '0;
        else if (pg_cnt_q == `CNT_W'(`PG_FALL_CYC - 1)) begin
          pg_cnt_q <= '0;
          o_powergood[g] <= 1'b0;
        end else pg_cnt_q <= pg_cnt_q + `CNT_W'(1);
      end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        o_discharge[g] <= 1'b0;
        o_softstart_run[g] <= 1'b0;
      end else begin
        o_discharge[g] <= !en_s[g] && dis_en_q && strap_ok_q;
        o_softstart_run[g] <= active[g] && !any_latched;
      end
    end

    // checks
    a_pg_hold_low: assert property (@(posedge i_clk) disable iff (i_rst)
      !qualify[g] |=> !o_powergood[g])
      else $error("powergood high while not qualified");
    a_pg_rise_delay: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(o_powergood[g]) |-> $past(pg_cnt_q) == `CNT_W'(PG_RISE_CYCLES - 1) && $past(in5_s[g]))
      else $error("powergood rose without full delay");
    a_pg_fall_filter: assert property (@(posedge i_clk) disable iff (i_rst)
      o_powergood[g] && qualify[g] && !out10_s[g] |=> o_powergood[g])
      else $error("powergood fell while in window");
    a_ov_latch: assert property (@(posedge i_clk) disable iff (i_rst)
      ov_s[g] && ovp_en_q && active[g] |=> ov_latch_q[g] ##2 !o_high_side_gate[g] && !o_high_side_gate[O])
      else $error("overvoltage did not latch");
    a_uv_latch: assert property (@(posedge i_clk) disable iff (i_rst)
      uv_latch_q[g] && !latch_clear |=> ##1 !o_high_side_gate[g] && !o_low_side_gate[g])
      else $error("undervoltage latch left gates on");
    a_uv_arm: assert property (@(posedge i_clk) disable iff (i_rst)
      !ssd_s[g] && !uv_latch_q[g] |=> !uv_latch_q[g])
      else $error("undervoltage latched before soft-start end");
    a_discharge_on: assert property (@(posedge i_clk) disable iff (i_rst)
      !en_s[g] && dis_en_q && strap_ok_q |=> o_discharge[g])
      else $error("discharge not on while disabled");
  end

  a_latch_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    lock_any |=> !any_latched)
    else $error("latch not cleared by lockout");
  a_lockout_rails: assert property (@(posedge i_clk) disable iff (i_rst)
    lk3_s |=> !o_rail_5v_regulator_en && !o_reference_2v_en && o_high_side_gate == 2'h0)
    else $error("3.3V lockout left outputs on");
  a_thermal: assert property (@(posedge i_clk) disable iff (i_rst)
    ot_s |=> o_rail_3v3_limit_low && !o_rail_5v_regulator_en && o_high_side_gate == 2'h0)
    else $error("thermal shutdown incomplete");
  a_phase_edges: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_high_side_gate[1]) |-> $past(!sclk_s && sclk_prev_q, 2))
    else $error("channel 2 cycle not started on falling edge");
endmodule // buck_protection_sequencer

// *** gate_driver_model.sv ***
// far-side model: gate drivers that count shoot-through, plus the switching clock source
// assumes gate levels from the sequencer and the bench clock and reset
`timescale 1ns/1ps
module gate_driver_model #(
  parameter int HALF_CYC = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_high_side_gate,
  input wire logic [1:0] i_low_side_gate,
  output logic o_sync_clk,
  output logic [15:0] o_overlap_count
);
  int half_cnt;
  // ==========================================
  // switching clock, free running, half period above four clocks
  always_ff @(negedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      half_cnt <= 0;
      o_sync_clk <= 1'b0;
    end else if (half_cnt == HALF_CYC - 1) begin
      half_cnt <= 0;
      o_sync_clk <= ~o_sync_clk;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end
  // ==========================================
  // both switches of one leg on together
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_overlap_count <= 16'h0;
    end else if ((i_high_side_gate & i_low_side_gate) != 2'h0) begin
      o_overlap_count <= o_overlap_count + 16'h1;
    end
  end
endmodule // gate_driver_model

// *** test_buck_protection_sequencer.sv ***
// self-checking bench for the buck protection sequencer
// assumes the gate driver model supplies the switching clock
`timescale 1ns/1ps
module test_buck_protection_sequencer;
  import buck_seq_pkg::*;
  localparam int PG_N = 20;
  localparam int UV_N = 20;
  logic clk = 0, rst = 1, ge = 0, fsp, lk5 = 0, lk3 = 0, lkr = 0, ot = 0;
  logic [1:0] en = 0, trip = 0, function_strap = 0, peak = 0, overcurrent_limit = 0, in5 = 0, out10 = 0, ov = 0, uv = 0, ssd = 0, tar = 0;
  logic [1:0] hi, lo, pg, dis, ssr;
  logic r5, rref, lim, ocll, cur;
  logic [15:0] ovl;
  integer seed = 4;
  int err_count = 0, checked = 0, run, mx, falls;

  buck_protection_sequencer #(.PG_RISE_CYCLES(PG_N), .UV_DELAY_CYCLES(UV_N)) dut (
    .i_clk(clk), .i_rst(rst), .i_global_enable(ge), .i_channel_enable(en), .i_frequency_set_pin(fsp),
    .i_trip_strap(trip), .i_function_strap(function_strap), .i_peak_reached(peak), .i_ocl_trip(overcurrent_limit),
    .i_within_5pct(in5), .i_outside_10pct(out10), .i_over_15pct(ov), .i_under_70pct(uv),
    .i_softstart_done(ssd), .i_target_above_residual(tar), .i_lockout_5v(lk5), .i_lockout_3v3(lk3),
    .i_lockout_ref(lkr), .i_over_temp(ot), .o_high_side_gate(hi), .o_low_side_gate(lo), .o_powergood(pg),
    .o_discharge(dis), .o_softstart_run(ssr), .o_rail_5v_regulator_en(r5), .o_reference_2v_en(rref),
    .o_rail_3v3_limit_low(lim), .o_ocl_level_low(ocll), .o_current_mode(cur));

  gate_driver_model drv (.i_clk(clk), .i_rst(rst), .i_high_side_gate(hi), .i_low_side_gate(lo),
    .o_sync_clk(fsp), .o_overlap_count(ovl));

  initial begin
    forever #20 clk = ~clk;
  end

  // ==========================================
  // helpers
  function automatic logic outer_code(input logic [1:0] c);
    return (c == 2'h0) || (c == 2'h3);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wrap_up;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_high(input int c);
    int n;
    n = 0;
    while (hi[c] !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    checked++;
    if (n == 300) begin
      err_count++;
      $display("mismatch at %0t: high side gate never switched on", $time);
      wrap_up();
    end
  endtask

  task automatic rst_dut;
    rst = 1;
    tick(20);
    check(4'({hi, lo} | pg), 4'h0, "outputs in reset");
    rst = 0;
    tick(8);
  endtask

  // ==========================================
  // main sequence
  initial begin
    ge = 1;
    for (int k = 0; k < 4; k++) begin
      trip = 2'(k);
      function_strap = 2'(k + 1);
      rst_dut();
      check(4'(ocll), 4'(trip[1]), "trip level");
      check(4'(cur), 4'(outer_code(function_strap)), "control mode");
      check(4'(dis), 4'({2{outer_code(trip)}}), "discharge");
    end
    trip = 0;
    function_strap = 0;
    rst_dut();
    en = 2'h3;
    tick(6);
    check(4'(dis), 4'h0, "discharge after enable");
    check(4'(ssr), 4'h3, "soft-start run");
    tick(30);
    check({hi, lo}, 4'h0, "ramp below residual");
    tar = 2'h3;
    uv = 2'h3;
    in5 = 2'h3;
    for (int i = 0; i < 300; i++) begin
      peak = 2'($random(seed));
      tick(1);
    end
    uv = 0;
    check(4'(pg), 4'h0, "powergood in soft-start");
    wait_high(0);
    wait_high(1);
    in5 = 0;
    ssd = 2'h3;
    tick(10);
    in5 = 2'h3;
    tick(PG_N - 2);
    check(4'(pg), 4'h0, "powergood early");
    tick(8);
    check(4'(pg), 4'h3, "powergood rise");
    in5 = 0;
    out10 = 2'h3;
    tick(20);
    in5 = 2'h3;
    out10 = 0;
    tick(6);
    check(4'(pg), 4'h3, "short excursion");
    in5 = 0;
    out10 = 2'h3;
    tick(30);
    check(4'(pg), 4'h3, "fall filter early");
    tick(14);
    check(4'(pg), 4'h0, "powergood fall");
    in5 = 2'h3;
    out10 = 0;
    tick(PG_N + 8);
    uv = 2'h2;
    tick(UV_N - 6);
    uv = 0;
    tick(10);
    check(4'(pg), 4'h3, "undervoltage recovery");
    uv = 2'h2;
    tick(UV_N + 8);
    uv = 0;
    check({hi, lo}, 4'h0, "undervoltage latch");
    check(4'(pg), 4'h0, "powergood when latched");
    en = 0;
    tick(6);
    en = 2'h3;
    wait_high(1);
    ov = 2'h1;
    tick(4);
    ov = 0;
    tick(6);
    check({hi, lo}, 4'h1, "overvoltage latch");
    tick(30);
    check({hi, lo}, 4'h1, "latch holds");
    ge = 0;
    tick(6);
    ge = 1;
    wait_high(0);
    peak = 0;
    tick(20);
    wait_high(0);
    overcurrent_limit = 2'h1;
    tick(2);
    overcurrent_limit = 0;
    tick(2);
    check(4'({hi[0], lo[0]}), 4'h1, "overcurrent cutoff");
    run = 0;
    mx = 0;
    falls = 0;
    for (int i = 0; i < 300; i++) begin
      tick(1);
      if (hi[0] === 1'b1) run++;
      else if (run > 0) begin
        falls++;
        run = 0;
      end
      if (run > mx) mx = run;
    end
    check(4'(mx <= 68), 4'h1, "extended on time");
    check(4'(falls > 0), 4'h1, "forced off");
    for (int k = 0; k < 5; k++) begin
      {lk5, lk3, lkr, ot} = (k == 0) ? 4'h0 : 4'(1 << (4 - k));
      tick(6);
      check(4'({r5, rref, lim}), 4'({~(lk3 | lkr | ot), ~lk3, ot}), "rail table");
      if (k > 0) check({hi, lo}, 4'h0, "channels off on fault");
    end
    check(4'(ovl != 16'h0), 4'h0, "shoot-through");
    wrap_up();
  end
endmodule // test_buck_protection_sequencer
